// ==== tsm_pkg.sv ====
// Shared constants and types for the TDM byte slot mapper
package tsm_pkg;

  // Bus geometry
  localparam int AXI_AW = 18;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IN_MAP_IDX = 16'hF300;
  localparam logic [15:0] OUT_MAP_IDX = 16'hF380;
  localparam logic [15:0] CTRL_IDX = 16'hF3C0;
  localparam logic [15:0] STAT_IDX = 16'hF3C1;
  localparam logic [15:0] CHIN_IDX = 16'hF3D0;
  localparam logic [15:0] CHOUT_IDX = 16'hF3E0;

  // Decoded register regions
  localparam logic [2:0] RG_NONE = 3'h0;
  localparam logic [2:0] RG_IN = 3'h1;
  localparam logic [2:0] RG_OUT = 3'h2;
  localparam logic [2:0] RG_CTRL = 3'h3;
  localparam logic [2:0] RG_STAT = 3'h4;
  localparam logic [2:0] RG_CHIN = 3'h5;
  localparam logic [2:0] RG_CHOUT = 3'h6;

  // Slot map fields and reset value
  localparam int EN_BIT = 7;
  localparam int REV_BIT = 6;
  localparam int SEL_BIT = 5;
  localparam logic [15:0] MAP_RST = 16'h0000;

  // Serial framing
  localparam logic [7:0] LAST_BIT = 8'hFF;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [2:0] BYTE_FIRST = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Receive buffer: {channel 4, byte position 2, data 8}
  localparam int ENTRY_W = 14;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    FR_IDLE = 2'h1,
    FR_RUN = 2'h2
  } tsm_frame_type;

endpackage : tsm_pkg

// ==== tsm_fifo2.sv ====
// Small valid/ready buffer in the receive path
module tsm_fifo2 #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } tsm_fifo_type;

  tsm_fifo_type r;
  tsm_fifo_type n;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = r.cnt != (PW+1)'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign out_data = r.mem[r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    if (push & ~pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop & ~push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule : tsm_fifo2

// ==== tsm_slot_mapper.sv ====
// Flexible TDM byte slot mapper with AXI4-Lite register access
//
// Summary of operation
// - Input channel position codes 010..111 pick channels 2..7 of the TDM8 stream.
// - Input byte position picks which byte of the selected channel is filled.
// - Byte code 00 is bits 31..24, 01 23..16, 10 15..8, 11 7..0.
// - Sixty-four output slot map registers, one byte per slot.
// - Output slots 0..31 leave on pin b, slots 32..63 on pin c.
// - Low six map bits pick the channel byte that feeds an output slot.
// - Disabled slot with high-Z option set leaves the pin undriven all slot.
// - Disabled slot with high-Z option clear drives the pin low all slot.
// - Enabled output slot carries its mapped channel byte.
// - Output maps sit at indices F380..F3BF and reset to zero.
// - Input pin select places a byte in channels 32..39 or 40..47.
// - Disabled input slots are ignored; enabled ones write their channel byte.
// - Input reverse bit flips the received byte's bit order before storage.
module tsm_slot_mapper (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AXI4-Lite write address
  input wire logic [tsm_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [tsm_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial TDM pins
  input wire logic tdm_bclk,
  input wire logic tdm_fsync,
  input wire logic serial_data_input_b,
  input wire logic serial_data_input_c,
  output logic serial_data_output_b,
  output logic serial_data_output_b_oe_n,
  output logic serial_data_output_c,
  output logic serial_data_output_c_oe_n
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [15:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [63:0][15:0] map_in;
    logic [63:0][15:0] map_out;
    logic [1:0] hz;
    logic ovr;
    logic [15:0][31:0] chan_in;
    logic [15:0][31:0] chan_out;
    logic [1:0] bclk_s;
    logic [1:0] fs_s;
    logic [1:0][1:0] di_s;
    logic bclk_d;
    logic fs_d;
    tsm_pkg::tsm_frame_type fr;
    logic [7:0] bit_cnt;
    logic [1:0][7:0] sh;
    logic [1:0][7:0] tx;
    logic [1:0] sdo;
    logic [1:0] oe_n;
    logic pa_v;
    logic pb_v;
    logic [13:0] pa_d;
    logic [13:0] pb_d;
  } tsm_state_type;

  tsm_state_type r;
  tsm_state_type n;

  // Byte lane of a 32-bit channel word, first byte is the top lane
  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] p);
    case (p)
      2'h0: byte_of = w[31:24];
      2'h1: byte_of = w[23:16];
      2'h2: byte_of = w[15:8];
      default: byte_of = w[7:0];
    endcase
  endfunction : byte_of

  function automatic logic [7:0] bitrev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bitrev8[i] = b[7-i];
    end
  endfunction : bitrev8

  // Byte-enable merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction : merge

  // Receive entry from an input map: channel 32+m[5:2], byte m[1:0]
  function automatic logic [13:0] rx_entry(input logic [15:0] m, input logic [1:0][7:0] b);
    logic [7:0] d;
    d = m[tsm_pkg::SEL_BIT] ? b[1] : b[0];
    rx_entry = {m[5:0], m[tsm_pkg::REV_BIT] ? bitrev8(d) : d};
  endfunction : rx_entry

  // Bases are aligned, so the low index bits are the entry number
  function automatic logic [2:0] region(input logic [15:0] i);
    if (i[15:6] == tsm_pkg::IN_MAP_IDX[15:6]) begin
      region = tsm_pkg::RG_IN;
    end else if (i[15:6] == tsm_pkg::OUT_MAP_IDX[15:6]) begin
      region = tsm_pkg::RG_OUT;
    end else if (i == tsm_pkg::CTRL_IDX) begin
      region = tsm_pkg::RG_CTRL;
    end else if (i == tsm_pkg::STAT_IDX) begin
      region = tsm_pkg::RG_STAT;
    end else if (i[15:4] == tsm_pkg::CHIN_IDX[15:4]) begin
      region = tsm_pkg::RG_CHIN;
    end else if (i[15:4] == tsm_pkg::CHOUT_IDX[15:4]) begin
      region = tsm_pkg::RG_CHOUT;
    end else begin
      region = tsm_pkg::RG_NONE;
    end
  endfunction : region

  // Serial timing decode from synchronised pins
  logic bclk_rise;
  logic bclk_fall;
  logic fs_start;
  logic run_step;
  logic [7:0] cnt_now;
  logic rx_done;
  logic [4:0] rx_slot;
  logic [1:0][7:0] rx_byte;
  logic [15:0] mlo;
  logic [15:0] mhi;
  logic busy;
  logic tx_load;
  logic [4:0] tx_slot;
  logic [1:0][15:0] mo;
  logic wr_go;
  logic [2:0] wr_rg;

  assign bclk_rise = r.bclk_s[1] & ~r.bclk_d;
  assign bclk_fall = ~r.bclk_s[1] & r.bclk_d;
  assign fs_start = bclk_rise & r.fs_s[1] & ~r.fs_d;
  assign run_step = bclk_rise & ~fs_start & (r.fr == tsm_pkg::FR_RUN) & (r.bit_cnt != tsm_pkg::LAST_BIT);
  assign cnt_now = r.bit_cnt + 8'h01;
  assign rx_done = run_step & (cnt_now[2:0] == tsm_pkg::BYTE_LAST);
  assign rx_slot = cnt_now[7:3];
  assign rx_byte[0] = {r.sh[0][6:0], r.di_s[0][1]};
  assign rx_byte[1] = {r.sh[1][6:0], r.di_s[1][1]};
  // Two input maps may claim one slot number, one per pin or both on one pin
  assign mlo = r.map_in[{1'b0, rx_slot}];
  assign mhi = r.map_in[{1'b1, rx_slot}];
  assign busy = r.pa_v | r.pb_v;
  assign tx_load = bclk_fall & (r.fr == tsm_pkg::FR_RUN) & (r.bit_cnt[2:0] == tsm_pkg::BYTE_FIRST);
  assign tx_slot = r.bit_cnt[7:3];
  assign mo[0] = r.map_out[{1'b0, tx_slot}];
  assign mo[1] = r.map_out[{1'b1, tx_slot}];
  assign wr_go = r.aw_held & r.w_held & ~r.bvalid;
  assign wr_rg = region(r.aw_idx);

  // Receive buffer between slot capture and channel storage
  logic buf_iv;
  logic buf_ir;
  logic buf_ov;
  logic [13:0] buf_od;
  logic drain_rdy;

  assign buf_iv = busy;
  // A bus write into the input channels stalls the drain for that cycle
  assign drain_rdy = ~(wr_go & (wr_rg == tsm_pkg::RG_CHIN));

  tsm_fifo2 #(
    .WIDTH(tsm_pkg::ENTRY_W),
    .DEPTH(tsm_pkg::BUF_DEPTH)
  ) u_rx_buf (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(buf_iv),
    .in_data(r.pa_v ? r.pa_d : r.pb_d),
    .in_ready(buf_ir),
    .out_valid(buf_ov),
    .out_data(buf_od),
    .out_ready(drain_rdy)
  );

  // Next state of the whole block
  always_comb begin
    logic [15:0] ri;
    logic [31:0] mw;
    ri = s_axi_araddr[tsm_pkg::AXI_AW-1:2];
    mw = 32'h00000000;
    n = r;
    // Pins are asynchronous to clk_sys
    n.bclk_s = {r.bclk_s[0], tdm_bclk};
    n.fs_s = {r.fs_s[0], tdm_fsync};
    n.di_s[0] = {r.di_s[0][0], serial_data_input_b};
    n.di_s[1] = {r.di_s[1][0], serial_data_input_c};
    n.bclk_d = r.bclk_s[1];
    // Frame bit counter, slot n spans bits 8n..8n+7
    if (fs_start) begin
      n.fr = tsm_pkg::FR_RUN;
      n.bit_cnt = 8'h00;
    end else if (run_step) begin
      n.bit_cnt = cnt_now;
    end else if (bclk_rise & (r.fr == tsm_pkg::FR_RUN)) begin
      n.fr = tsm_pkg::FR_IDLE;
    end
    if (bclk_rise) begin
      n.fs_d = r.fs_s[1];
      n.sh = rx_byte;
    end
    // Transmit: load on the slot's first falling edge, then shift MSB first
    for (int p = 0; p < 2; p++) begin
      if (tx_load) begin
        if (mo[p][tsm_pkg::EN_BIT]) begin
          n.tx[p] = byte_of(r.chan_out[mo[p][5:2]], mo[p][1:0]);
          n.sdo[p] = n.tx[p][7];
          n.oe_n[p] = 1'b0;
        end else begin
          n.tx[p] = 8'h00;
          n.sdo[p] = 1'b0;
          n.oe_n[p] = r.hz[p];
        end
      end else if (bclk_fall & (r.fr == tsm_pkg::FR_RUN)) begin
        n.tx[p] = {r.tx[p][6:0], 1'b0};
        n.sdo[p] = r.tx[p][6];
      end else if (bclk_fall) begin
        n.sdo[p] = 1'b0;
        n.oe_n[p] = r.hz[p];
      end
    end
    // Hand pending entries to the buffer, first map before second
    if (buf_ir) begin
      if (r.pa_v) begin
        n.pa_v = 1'b0;
      end else begin
        n.pb_v = 1'b0;
      end
    end
    // Drain into channel storage at the mapped byte lane
    if (buf_ov & drain_rdy) begin
      case (buf_od[9:8])
        2'h0: n.chan_in[buf_od[13:10]][31:24] = buf_od[7:0];
        2'h1: n.chan_in[buf_od[13:10]][23:16] = buf_od[7:0];
        2'h2: n.chan_in[buf_od[13:10]][15:8] = buf_od[7:0];
        default: n.chan_in[buf_od[13:10]][7:0] = buf_od[7:0];
      endcase
    end
    // Bus write channel, address and data taken in either order
    if (r.bvalid & s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid & r.awready) begin
      n.aw_held = 1'b1;
      n.awready = 1'b0;
      n.aw_idx = s_axi_awaddr[tsm_pkg::AXI_AW-1:2];
    end
    if (s_axi_wvalid & r.wready) begin
      n.w_held = 1'b1;
      n.wready = 1'b0;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.bvalid = 1'b1;
      n.bresp = tsm_pkg::RESP_OKAY;
      if (wr_rg == tsm_pkg::RG_IN) begin
        mw = merge({16'h0000, r.map_in[r.aw_idx[5:0]]}, r.w_data, r.w_strb);
        n.map_in[r.aw_idx[5:0]] = mw[15:0];
      end else if (wr_rg == tsm_pkg::RG_OUT) begin
        mw = merge({16'h0000, r.map_out[r.aw_idx[5:0]]}, r.w_data, r.w_strb);
        n.map_out[r.aw_idx[5:0]] = mw[15:0];
      end else if (wr_rg == tsm_pkg::RG_CTRL) begin
        if (r.w_strb[0]) begin
          n.hz = r.w_data[1:0];
        end
      end else if (wr_rg == tsm_pkg::RG_STAT) begin
        if (r.w_strb[0] & r.w_data[0]) begin
          n.ovr = 1'b0;
        end
      end else if (wr_rg == tsm_pkg::RG_CHIN) begin
        n.chan_in[r.aw_idx[3:0]] = merge(r.chan_in[r.aw_idx[3:0]], r.w_data, r.w_strb);
      end else if (wr_rg == tsm_pkg::RG_CHOUT) begin
        n.chan_out[r.aw_idx[3:0]] = merge(r.chan_out[r.aw_idx[3:0]], r.w_data, r.w_strb);
      end else begin
        n.bresp = tsm_pkg::RESP_SLVERR;
      end
    end
    // Slot capture after the bus clear, so a new overrun wins
    if (rx_done) begin
      if (busy) begin
        n.ovr = 1'b1;
      end else begin
        n.pa_v = mlo[tsm_pkg::EN_BIT];
        n.pa_d = rx_entry(mlo, rx_byte);
        n.pb_v = mhi[tsm_pkg::EN_BIT];
        n.pb_d = rx_entry(mhi, rx_byte);
      end
    end
    // Bus read channel, data one cycle after the address
    if (r.rvalid & s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_arvalid & r.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = tsm_pkg::RESP_OKAY;
      n.rdata = 32'h00000000;
      case (region(ri))
        tsm_pkg::RG_IN: n.rdata = {16'h0000, r.map_in[ri[5:0]]};
        tsm_pkg::RG_OUT: n.rdata = {16'h0000, r.map_out[ri[5:0]]};
        tsm_pkg::RG_CTRL: n.rdata = {30'h00000000, r.hz};
        tsm_pkg::RG_STAT: n.rdata = {16'h0000, r.bit_cnt, 6'h00, r.fr == tsm_pkg::FR_RUN, r.ovr};
        tsm_pkg::RG_CHIN: n.rdata = r.chan_in[ri[3:0]];
        tsm_pkg::RG_CHOUT: n.rdata = r.chan_out[ri[3:0]];
        default: n.rresp = tsm_pkg::RESP_SLVERR;
      endcase
    end
  end

  // State register; maps clear to all slots disabled
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.fr <= tsm_pkg::FR_IDLE;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state flops
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
  assign serial_data_output_b = r.sdo[0];
  assign serial_data_output_b_oe_n = r.oe_n[0];
  assign serial_data_output_c = r.sdo[1];
  assign serial_data_output_c_oe_n = r.oe_n[1];

  // Checks on the mapping behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  AST_RX_MAP:
    assert property (rx_done & ~busy & mlo[7] |=> r.pa_v && r.pa_d[13:8] == $past(mlo[5:0]))
    else $error("input slot not mapped to its channel byte");
  AST_RX_OFF:
    assert property (rx_done & ~busy & ~mlo[7] & ~mhi[7] |=> !r.pa_v && !r.pb_v)
    else $error("disabled input slot was captured");
  AST_RX_REV:
    assert property (rx_done & ~busy & mlo[7] & mlo[6] & ~mlo[5] |=> r.pa_d[7:0] == bitrev8($past(rx_byte[0])))
    else $error("reversed input byte has wrong bit order");
  AST_LANE:
    assert property (buf_ov & drain_rdy |=>
      byte_of(r.chan_in[$past(buf_od[13:10])], $past(buf_od[9:8])) == $past(buf_od[7:0]))
    else $error("received byte stored in wrong lane");
  AST_HZ:
    assert property (tx_load & ~mo[1][7] & r.hz[1] |=> r.oe_n[1])
    else $error("disabled slot drove pin with high-z option set");
  AST_HOLD:
    assert property (~tx_load & ~bclk_fall |=> $stable(r.oe_n) && $stable(r.sdo))
    else $error("pin changed inside a bit period");
  AST_LOW:
    assert property (tx_load & ~mo[0][7] & ~r.hz[0] |=> !r.oe_n[0] && !r.sdo[0])
    else $error("disabled slot not driven low");
  AST_DATA:
    assert property (tx_load & mo[1][7] |=>
      !r.oe_n[1] && r.tx[1] == $past(byte_of(r.chan_out[mo[1][5:2]], mo[1][1:0])) && r.sdo[1] == r.tx[1][7])
    else $error("enabled slot did not send its mapped byte");
  AST_CNT:
    assert property (run_step |=> r.bit_cnt == $past(r.bit_cnt) + 8'h01)
    else $error("bit counter did not advance by one");
  AST_RST:
    assert property ($fell(sys_rst) |-> r.map_out == '0 && r.map_in == '0)
    else $error("slot maps not cleared by reset");
  AST_WR_MAP:
    assert property (wr_go & wr_rg == tsm_pkg::RG_OUT & r.w_strb == 4'hF |=>
      r.map_out[$past(r.aw_idx[5:0])] == $past(r.w_data[15:0]))
    else $error("output map write lost");

endmodule : tsm_slot_mapper

// ==== tsm_tdm_peer.sv ====
// Behavioural model of the external TDM devices on the serial data pins
module tsm_tdm_peer #(
  parameter int HALF_NS = 50
) (
  // Clock and frame pins driven by the far side
  output logic bclk,
  output logic fsync,
  // Serial data into the block
  output logic sdi_b,
  output logic sdi_c,
  // Serial data out of the block
  input wire logic sdo_b,
  input wire logic sdo_b_oe_n,
  input wire logic sdo_c,
  input wire logic sdo_c_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Captured output bits and high-Z flags, slot 0 in the top byte
  logic [255:0] cap_b;
  logic [255:0] cap_c;
  logic [255:0] hz_b;
  logic [255:0] hz_c;

  // Pins idle with the bit clock parked low between frames
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    sdi_b = 1'b0;
    sdi_c = 1'b1;
  end

  // One frame of 32 eight-bit slots, ascending after the sync pulse
  task automatic run_frame(input logic [255:0] fb, input logic [255:0] fc);
    int p;
    // Step off the system clock edge so no pin moves while the block samples it
    #1;
    for (p = 0; p < 257; p++) begin
      fsync = (p == 0);
      if (p < 256) begin
        sdi_b = fb[255-p];
        sdi_c = fc[255-p];
      end else begin
        // Released lines flip so a stale value is never mistaken for data
        sdi_b = ~sdi_b;
        sdi_c = ~sdi_c;
      end
      #(HALF_NS);
      // Output for bit p-1 is launched one fall late, so it is read here
      if (p > 0) begin
        cap_b[256-p] = sdo_b;
        cap_c[256-p] = sdo_c;
        hz_b[256-p] = sdo_b_oe_n;
        hz_c[256-p] = sdo_c_oe_n;
      end
      bclk = 1'b1;
      #(HALF_NS);
      bclk = 1'b0;
    end
    fsync = 1'b0;
  endtask : run_frame
endmodule : tsm_tdm_peer

// ==== tb.sv ====
// Self-checking testbench for the TDM byte slot mapper
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 30000;

  // Clock, reset and bus signals
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [tsm_pkg::AXI_AW-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [tsm_pkg::AXI_AW-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  // Serial pins
  logic tdm_bclk;
  logic tdm_fsync;
  logic sdi_b;
  logic sdi_c;
  logic sdo_b;
  logic sdo_b_oe_n;
  logic sdo_c;
  logic sdo_c_oe_n;
  // Bookkeeping
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [255:0] fb;
  logic [255:0] fc;
  logic [7:0] v;

  tsm_slot_mapper dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tdm_bclk(tdm_bclk), .tdm_fsync(tdm_fsync),
    .serial_data_input_b(sdi_b), .serial_data_input_c(sdi_c),
    .serial_data_output_b(sdo_b), .serial_data_output_b_oe_n(sdo_b_oe_n),
    .serial_data_output_c(sdo_c), .serial_data_output_c_oe_n(sdo_c_oe_n)
  );

  tsm_tdm_peer peer_u (
    .bclk(tdm_bclk), .fsync(tdm_fsync), .sdi_b(sdi_b), .sdi_c(sdi_c),
    .sdo_b(sdo_b), .sdo_b_oe_n(sdo_b_oe_n), .sdo_c(sdo_c), .sdo_c_oe_n(sdo_c_oe_n)
  );

  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard: a stuck handshake still ends in the report
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [15:0] idx, input logic [31:0] dat, output logic [1:0] resp);
    logic a_ok;
    logic w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dat;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (!a_ok && s_axi_awready) begin
        a_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        dat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  // Write expected to succeed
  task automatic wrk(input logic [15:0] idx, input logic [31:0] dat);
    logic [1:0] resp;
    wr(idx, dat, resp);
    chk({30'h0, resp}, {30'h0, tsm_pkg::RESP_OKAY}, "write response");
  endtask : wrk

  function automatic logic [7:0] rev8(input logic [7:0] x);
    int i;
    for (i = 0; i < 8; i++) begin
      rev8[i] = x[7-i];
    end
  endfunction : rev8

  // Drive state of one captured output slot, then its data when driven
  task automatic chk_slot(input logic pin_c, input int s, input logic [7:0] e, input logic hz);
    logic [7:0] dv;
    logic [7:0] zv;
    dv = pin_c ? peer_u.cap_c[255-8*s -: 8] : peer_u.cap_b[255-8*s -: 8];
    zv = pin_c ? peer_u.hz_c[255-8*s -: 8] : peer_u.hz_b[255-8*s -: 8];
    chk({24'h0, zv}, hz ? 32'h0000_00FF : 32'h0, "slot drive");
    if (!hz) begin
      chk({24'h0, dv}, {24'h0, e}, "slot data");
    end
  endtask : chk_slot

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Register reset values, read/write and an unmapped place
    rd(tsm_pkg::OUT_MAP_IDX, d, r);
    chk(d, 32'h0, "first map reset");
    rd(tsm_pkg::OUT_MAP_IDX + 16'h003F, d, r);
    chk(d, 32'h0, "last map reset");
    wrk(tsm_pkg::OUT_MAP_IDX + 16'h003F, 32'h0000_AB80);
    rd(tsm_pkg::OUT_MAP_IDX + 16'h003F, d, r);
    chk(d, 32'h0000_AB80, "last map readback");
    rd(16'h0000, d, r);
    chk({30'h0, r}, {30'h0, tsm_pkg::RESP_SLVERR}, "unmapped read");
    wr(16'h0000, 32'h1, r);
    chk({30'h0, r}, {30'h0, tsm_pkg::RESP_SLVERR}, "unmapped write");
    $display("test registers done");
    // Input slots: channel positions 0..7 and every byte code, odd slots reversed
    for (int s = 0; s < 8; s++) begin
      v = 8'(s);
      wrk(tsm_pkg::IN_MAP_IDX + 16'(s), {24'h0, 1'b1, v[0], 1'b0, v[2:0], v[1:0]});
    end
    wrk(tsm_pkg::IN_MAP_IDX + 16'h0008, 32'h0000_00A1);
    wrk(tsm_pkg::IN_MAP_IDX + 16'h0009, 32'h0000_0002);
    fb = '0;
    fc = '0;
    for (int s = 0; s < 10; s++) begin
      fb[255-8*s -: 8] = 8'hA0 + 8'(s);
      fc[255-8*s -: 8] = 8'h50 + 8'(s);
    end
    peer_u.run_frame(fb, fc);
    repeat (8) @(posedge clk_sys);
    for (int s = 0; s < 8; s++) begin
      v = (s % 2 == 1) ? rev8(8'hA0 + 8'(s)) : 8'hA0 + 8'(s);
      rd(tsm_pkg::CHIN_IDX + 16'(s), d, r);
      chk(d, {24'h0, v} << (8 * (3 - s % 4)), "input channel");
    end
    rd(tsm_pkg::CHIN_IDX + 16'h0008, d, r);
    chk(d, 32'h0058_0000, "pin c channel");
    $display("test input mapping done");
    // Output slots: enabled, driven low, high-Z, both pins and last slots
    wrk(tsm_pkg::CTRL_IDX, 32'h0000_0002);
    rd(tsm_pkg::CTRL_IDX, d, r);
    chk(d, 32'h0000_0002, "high-z select readback");
    wrk(tsm_pkg::CHOUT_IDX, 32'h1234_5678);
    wrk(tsm_pkg::CHOUT_IDX + 16'h0009, 32'h9ABC_DEF0);
    wrk(tsm_pkg::OUT_MAP_IDX, 32'h0000_0081);
    wrk(tsm_pkg::OUT_MAP_IDX + 16'h001F, 32'h0000_0083);
    wrk(tsm_pkg::OUT_MAP_IDX + 16'h0021, 32'h0000_00A7);
    peer_u.run_frame('0, '0);
    chk_slot(1'b0, 0, 8'h34, 1'b0);
    chk_slot(1'b0, 1, 8'h00, 1'b0);
    chk_slot(1'b0, 31, 8'h78, 1'b0);
    chk_slot(1'b1, 0, 8'h00, 1'b1);
    chk_slot(1'b1, 1, 8'hF0, 1'b0);
    chk_slot(1'b1, 31, 8'h12, 1'b0);
    $display("test output mapping done");
    final_report();
  end
endmodule : tb
